// ==== verilog/icf_pkg.sv ====
package icf_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_KEYED_CONFIG = 12'h048;
    localparam logic [11:0] OFF_GLOBAL_IRQ_STATUS = 12'h04C;
    localparam logic [11:0] OFF_FAST_VECTOR_NUMBER_CONFIG = 12'h050;
    localparam logic [11:0] OFF_FAST_VECTOR_ZERO_ADDRESS = 12'h060;
    localparam logic [11:0] OFF_FAST_VECTOR_ONE_ADDRESS = 12'h064;
    localparam logic [11:0] OFF_EVENT_STATUS = 12'h080;
    localparam logic [11:0] OFF_EVENT_MASK = 12'h084;
    localparam logic [11:0] OFF_SYSTEM_CONTROL_REGISTER = 12'h090;

    // ------------------------------------------------------------
    // keyed configuration and system control register fields
    // ------------------------------------------------------------
    localparam int KEY_MSB = 31;
    localparam int KEY_LSB = 16;
    localparam logic [15:0] UNLOCK_KEY_ONE = 16'hFA05;
    localparam logic [15:0] UNLOCK_KEY_TWO = 16'hBCAF;
    localparam logic [15:0] UNLOCK_KEY_THREE = 16'hBEEF;
    localparam int SYSTEM_RESET_REQUEST_BIT = 7;
    localparam int CONTROL_REG_RESET_BIT = 31;

    // ------------------------------------------------------------
    // global status fields
    // ------------------------------------------------------------
    localparam int ANY_PENDING_BIT = 9;
    localparam int ANY_ACTIVE_BIT = 8;
    localparam logic [7:0] NEST_NONE = 8'h00;
    localparam logic [7:0] NEST_LEVEL_ONE = 8'h01;
    localparam logic [7:0] NEST_LEVEL_TWO = 8'h03;
    localparam logic [1:0] NEST_MAX_DEPTH = 2'h2;

    // ------------------------------------------------------------
    // fast vector fields
    // ------------------------------------------------------------
    localparam int ID0_LSB = 0;
    localparam int ID1_LSB = 8;
    localparam int FAST_ENABLE_BIT = 0;

    // ------------------------------------------------------------
    // event status and mask layout
    // ------------------------------------------------------------
    localparam int EV_W = 4;
    localparam int EV_FAST0_HIT = 0;
    localparam int EV_FAST1_HIT = 1;
    localparam int EV_NEST_OVERFLOW = 2;
    localparam int EV_EXIT_UNDERFLOW = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_IDS = 16'h0000;
    localparam logic [3:0] RST_EV = 4'h0;
    localparam logic [1:0] RST_DEPTH = 2'h0;

endpackage

// ==== verilog/icf_fast_match.sv ====
`timescale 1ns/1ps

// one fast-vector channel: flags a taken interrupt that this channel owns
module icf_fast_match #(
    parameter int NUM_W = 8
) (
    // channel configuration
    input wire logic enable,
    input wire logic [NUM_W-1:0] irq_number,
    // interrupt being taken by the core
    input wire logic take,
    input wire logic [NUM_W-1:0] take_number,
    // result
    output logic hit
);

    assign hit = take && enable && (take_number == irq_number);

endmodule

// ==== verilog/icf_ctrl_top.sv ====
// Our own choice: the strobed register port.
`timescale 1ns/1ps

module icf_ctrl_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [icf_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [icf_pkg::DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [icf_pkg::DATA_W-1:0] bus_rdata,
    // interrupt state from the core and sources
    input wire logic irq_pending_any,
    input wire logic irq_enter,
    input wire logic [7:0] irq_enter_num,
    input wire logic irq_exit,
    // vectoring to the core
    output logic fast_vector_hit,
    output logic fast_vector_channel,
    output logic [31:0] fast_vector_address,
    // system reset and event interrupt
    output logic sys_reset_req,
    output logic event_irq
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [15:0] fast_ids;
    logic [31:0] fast0_reg;
    logic [31:0] fast1_reg;
    logic [icf_pkg::EV_W-1:0] ev_status;
    logic [icf_pkg::EV_W-1:0] ev_mask;
    logic [1:0] nest_depth;

    logic [7:0] fast_channel0_irq_number;
    logic [7:0] fast_channel1_irq_number;
    logic fast_channel0_enable;
    logic fast_channel1_enable;
    logic [31:0] fast_channel0_handler_address;
    logic [31:0] fast_channel1_handler_address;

    assign fast_channel0_irq_number = fast_ids[icf_pkg::ID0_LSB +: 8];
    assign fast_channel1_irq_number = fast_ids[icf_pkg::ID1_LSB +: 8];
    assign fast_channel0_enable = fast0_reg[icf_pkg::FAST_ENABLE_BIT];
    assign fast_channel1_enable = fast1_reg[icf_pkg::FAST_ENABLE_BIT];
    // handler addresses are halfword aligned, bit 0 is forced low
    assign fast_channel0_handler_address = {fast0_reg[31:1], 1'b0};
    assign fast_channel1_handler_address = {fast1_reg[31:1], 1'b0};

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    logic wr_cfg;
    logic wr_ids;
    logic wr_f0;
    logic wr_f1;
    logic wr_evs;
    logic wr_evm;
    logic wr_sctl;
    logic [15:0] unlock_key_field;
    logic reset_fire;

    always_comb
    begin
        wr_cfg = 1'b0;
        wr_ids = 1'b0;
        wr_f0 = 1'b0;
        wr_f1 = 1'b0;
        wr_evs = 1'b0;
        wr_evm = 1'b0;
        wr_sctl = 1'b0;
        if (bus_wr)
        begin
            if (bus_addr == icf_pkg::OFF_KEYED_CONFIG)
            begin
                wr_cfg = 1'b1;
            end
            else if (bus_addr == icf_pkg::OFF_FAST_VECTOR_NUMBER_CONFIG)
            begin
                wr_ids = 1'b1;
            end
            else if (bus_addr == icf_pkg::OFF_FAST_VECTOR_ZERO_ADDRESS)
            begin
                wr_f0 = 1'b1;
            end
            else if (bus_addr == icf_pkg::OFF_FAST_VECTOR_ONE_ADDRESS)
            begin
                wr_f1 = 1'b1;
            end
            else if (bus_addr == icf_pkg::OFF_EVENT_STATUS)
            begin
                wr_evs = 1'b1;
            end
            else if (bus_addr == icf_pkg::OFF_EVENT_MASK)
            begin
                wr_evm = 1'b1;
            end
            else if (bus_addr == icf_pkg::OFF_SYSTEM_CONTROL_REGISTER)
            begin
                wr_sctl = 1'b1;
            end
        end
    end

    assign unlock_key_field = bus_wdata[icf_pkg::KEY_MSB:icf_pkg::KEY_LSB];

    // a zero in the request bit, or a wrong key, is dropped silently
    // both reset sources feed the same one pulse
    assign reset_fire = (wr_cfg
        && bus_wdata[icf_pkg::SYSTEM_RESET_REQUEST_BIT]
        && (unlock_key_field == icf_pkg::UNLOCK_KEY_THREE))
        || (wr_sctl && bus_wdata[icf_pkg::CONTROL_REG_RESET_BIT]);

    // ------------------------------------------------------------
    // system reset request
    // ------------------------------------------------------------
    // the request never stores, so software never has to clear it
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sys_reset_req <= 1'b0;
        end
        else
        begin
            sys_reset_req <= reset_fire;
        end
    end

    a_reset_key_three: assert property (
        @(posedge core_clk) disable iff (rst)
        (wr_cfg && bus_wdata[7] && bus_wdata[31:16] == 16'hBEEF)
        |=> sys_reset_req)
        else $error("keyed reset write gave no reset pulse");

    a_reset_cause: assert property (
        @(posedge core_clk) disable iff (rst)
        sys_reset_req |-> $past(reset_fire)
        && ($past(wr_sctl) || $past(bus_wdata[31:16]) == 16'hBEEF))
        else $error("reset pulse without its key");

    a_reset_self_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        (sys_reset_req && !reset_fire) |=> !sys_reset_req)
        else $error("reset request did not clear itself");

    a_sctl_same_reset: assert property (
        @(posedge core_clk) disable iff (rst)
        (wr_sctl && bus_wdata[31]) |=> sys_reset_req)
        else $error("control register reset bit gave no reset");

    // ------------------------------------------------------------
    // fast vector configuration
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            fast_ids <= icf_pkg::RST_IDS;
        end
        else if (wr_ids)
        begin
            fast_ids <= bus_wdata[15:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            fast0_reg <= icf_pkg::RST_WORD;
            fast1_reg <= icf_pkg::RST_WORD;
        end
        else
        begin
            if (wr_f0)
            begin
                fast0_reg <= bus_wdata;
            end
            if (wr_f1)
            begin
                fast1_reg <= bus_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // nesting depth
    // ------------------------------------------------------------
    // a third entry is refused: the context stack has only two slots
    logic nest_overflow;
    logic exit_underflow;

    assign nest_overflow = irq_enter && !irq_exit
        && (nest_depth == icf_pkg::NEST_MAX_DEPTH);
    assign exit_underflow = irq_exit && !irq_enter
        && (nest_depth == icf_pkg::RST_DEPTH);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            nest_depth <= icf_pkg::RST_DEPTH;
        end
        else if (irq_enter && !irq_exit && !nest_overflow)
        begin
            nest_depth <= nest_depth + 2'h1;
        end
        else if (irq_exit && !irq_enter && !exit_underflow)
        begin
            nest_depth <= nest_depth - 2'h1;
        end
    end

    a_depth_cap: assert property (
        @(posedge core_clk) disable iff (rst)
        (nest_depth == 2'h2 && irq_enter && !irq_exit)
        |=> nest_depth == 2'h2)
        else $error("nesting went past two levels");

    // ------------------------------------------------------------
    // fast vector matching
    // ------------------------------------------------------------
    logic hit0;
    logic hit1;

    icf_fast_match #(
        .NUM_W(8)
    ) u_match0 (
        .enable(fast_channel0_enable),
        .irq_number(fast_channel0_irq_number),
        .take(irq_enter),
        .take_number(irq_enter_num),
        .hit(hit0)
    );

    icf_fast_match #(
        .NUM_W(8)
    ) u_match1 (
        .enable(fast_channel1_enable),
        .irq_number(fast_channel1_irq_number),
        .take(irq_enter),
        .take_number(irq_enter_num),
        .hit(hit1)
    );

    // channel 0 wins when both channels are set to the same number
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            fast_vector_hit <= 1'b0;
            fast_vector_channel <= 1'b0;
            fast_vector_address <= icf_pkg::RST_WORD;
        end
        else if (hit0)
        begin
            fast_vector_hit <= 1'b1;
            fast_vector_channel <= 1'b0;
            fast_vector_address <= fast_channel0_handler_address;
        end
        else if (hit1)
        begin
            fast_vector_hit <= 1'b1;
            fast_vector_channel <= 1'b1;
            fast_vector_address <= fast_channel1_handler_address;
        end
        else
        begin
            fast_vector_hit <= 1'b0;
            fast_vector_channel <= 1'b0;
            fast_vector_address <= icf_pkg::RST_WORD;
        end
    end

    a_fast0_handler: assert property (
        @(posedge core_clk) disable iff (rst)
        (irq_enter && fast0_reg[0] && irq_enter_num == fast_ids[7:0])
        |=> fast_vector_hit && !fast_vector_channel
        && fast_vector_address == {$past(fast0_reg[31:1]), 1'b0})
        else $error("channel 0 handler address not handed over");

    a_fast_disabled: assert property (
        @(posedge core_clk) disable iff (rst)
        (irq_enter && !fast0_reg[0])
        |=> !(fast_vector_hit && !fast_vector_channel))
        else $error("disabled fast path still vectored");

    // ------------------------------------------------------------
    // event status and interrupt
    // ------------------------------------------------------------
    logic [icf_pkg::EV_W-1:0] ev_set;

    always_comb
    begin
        ev_set = icf_pkg::RST_EV;
        ev_set[icf_pkg::EV_FAST0_HIT] = hit0;
        ev_set[icf_pkg::EV_FAST1_HIT] = hit1 && !hit0;
        ev_set[icf_pkg::EV_NEST_OVERFLOW] = nest_overflow;
        ev_set[icf_pkg::EV_EXIT_UNDERFLOW] = exit_underflow;
    end

    // a new event beats a write-one-to-clear in the same cycle
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ev_status <= icf_pkg::RST_EV;
        end
        else
        begin
            ev_status <= (ev_status
                & ~(wr_evs ? bus_wdata[icf_pkg::EV_W-1:0] : icf_pkg::RST_EV))
                | ev_set;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ev_mask <= icf_pkg::RST_EV;
        end
        else if (wr_evm)
        begin
            ev_mask <= bus_wdata[icf_pkg::EV_W-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            event_irq <= 1'b0;
        end
        else
        begin
            event_irq <= |(ev_status & ev_mask);
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [31:0] next_rdata;
    logic [7:0] nesting_state;

    always_comb
    begin
        nesting_state = icf_pkg::NEST_NONE;
        if (nest_depth == 2'h1)
        begin
            nesting_state = icf_pkg::NEST_LEVEL_ONE;
        end
        else if (nest_depth == icf_pkg::NEST_MAX_DEPTH)
        begin
            nesting_state = icf_pkg::NEST_LEVEL_TWO;
        end
    end

    // write-only and unmapped locations read as zero
    always_comb
    begin
        next_rdata = icf_pkg::RST_WORD;
        if (bus_addr == icf_pkg::OFF_GLOBAL_IRQ_STATUS)
        begin
            next_rdata[icf_pkg::ANY_PENDING_BIT] = irq_pending_any;
            next_rdata[icf_pkg::ANY_ACTIVE_BIT] = (nest_depth != 2'h0);
            next_rdata[7:0] = nesting_state;
        end
        else if (bus_addr == icf_pkg::OFF_FAST_VECTOR_NUMBER_CONFIG)
        begin
            next_rdata[15:0] = fast_ids;
        end
        else if (bus_addr == icf_pkg::OFF_FAST_VECTOR_ZERO_ADDRESS)
        begin
            next_rdata = fast0_reg;
        end
        else if (bus_addr == icf_pkg::OFF_FAST_VECTOR_ONE_ADDRESS)
        begin
            next_rdata = fast1_reg;
        end
        else if (bus_addr == icf_pkg::OFF_EVENT_STATUS)
        begin
            next_rdata[icf_pkg::EV_W-1:0] = ev_status;
        end
        else if (bus_addr == icf_pkg::OFF_EVENT_MASK)
        begin
            next_rdata[icf_pkg::EV_W-1:0] = ev_mask;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bus_rdata <= icf_pkg::RST_WORD;
        end
        else if (bus_rd)
        begin
            bus_rdata <= next_rdata;
        end
        else
        begin
            bus_rdata <= icf_pkg::RST_WORD;
        end
    end

    a_key_reads_zero: assert property (
        @(posedge core_clk) disable iff (rst)
        (bus_rd && bus_addr == 12'h048) |=> bus_rdata == 32'h0000_0000)
        else $error("keyed configuration read not zero");

    a_pending_flag: assert property (
        @(posedge core_clk) disable iff (rst)
        (bus_rd && bus_addr == 12'h04C)
        |=> bus_rdata[9] == $past(irq_pending_any) && bus_rdata[31:10] == 0)
        else $error("pending flag wrong");

    a_active_nest: assert property (
        @(posedge core_clk) disable iff (rst)
        (bus_rd && bus_addr == 12'h04C)
        |=> bus_rdata[8] == ($past(nest_depth) != 2'h0))
        else $error("active flag wrong");

    a_nest_code: assert property (
        @(posedge core_clk) disable iff (rst)
        (bus_rd && bus_addr == 12'h04C)
        |=> bus_rdata[7:0] == ($past(nest_depth) == 2'h2 ? 8'h03
        : ($past(nest_depth) == 2'h1 ? 8'h01 : 8'h00)))
        else $error("nesting code wrong");

endmodule

// ==== verification/icf_core_model.sv ====
`timescale 1ns/1ps

// core and interrupt sources: enters and leaves handlers as commanded
module icf_core_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // towards the controller
    output logic irq_pending_any,
    output logic irq_enter,
    output logic [7:0] irq_enter_num,
    output logic irq_exit
);
    initial
    begin
        irq_pending_any = 1'b0;
        irq_enter = 1'b0;
        irq_enter_num = 8'h00;
        irq_exit = 1'b0;
    end

    // the number is only qualified by the strobe; show garbage otherwise
    task automatic take(input logic [7:0] num);
        @(posedge core_clk);
        irq_enter <= 1'b1;
        irq_enter_num <= num;
        @(posedge core_clk);
        irq_enter <= 1'b0;
        irq_enter_num <= ~num;
    endtask

    // a third leave is commanded by the bench to probe the exit underflow
    task automatic leave();
        @(posedge core_clk);
        irq_exit <= 1'b1;
        @(posedge core_clk);
        irq_exit <= 1'b0;
    endtask

    task automatic pend(input logic v);
        @(posedge core_clk);
        irq_pending_any <= v;
    endtask
endmodule

// ==== verification/irq_config_status_fast_vector_tb.sv ====
`timescale 1ns/1ps

module irq_config_status_fast_vector_tb;
    typedef struct {
        logic [11:0] a;
        logic [31:0] w;
        logic [31:0] e;
    } icf_row_s;

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] bus_addr = 12'h000;
    logic [31:0] bus_wdata = 32'h0000_0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [31:0] bus_rdata;
    logic irq_pending_any;
    logic irq_enter;
    logic [7:0] irq_enter_num;
    logic irq_exit;
    logic fast_vector_hit;
    logic fast_vector_channel;
    logic [31:0] fast_vector_address;
    logic sys_reset_req;
    logic event_irq;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    icf_row_s rows [8];
    logic [15:0] keys [4];
    logic [3:0] bit7;
    logic [3:0] fires;

    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    icf_ctrl_top i_dut (
        .core_clk(core_clk), .rst(rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .irq_pending_any(irq_pending_any),
        .irq_enter(irq_enter), .irq_enter_num(irq_enter_num),
        .irq_exit(irq_exit), .fast_vector_hit(fast_vector_hit),
        .fast_vector_channel(fast_vector_channel),
        .fast_vector_address(fast_vector_address),
        .sys_reset_req(sys_reset_req), .event_irq(event_irq)
    );

    icf_core_model i_core (
        .core_clk(core_clk), .rst(rst),
        .irq_pending_any(irq_pending_any), .irq_enter(irq_enter),
        .irq_enter_num(irq_enter_num), .irq_exit(irq_exit)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge core_clk);
        bus_wr <= 1'b0;
        bus_wdata <= ~d;
        #1;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        #1;
        chk($sformatf("rdata@%h", a), e, bus_rdata);
    endtask

    // hit outputs stand for one cycle after the taking edge
    task automatic take_chk(input logic [7:0] n, input logic h,
                            input logic c, input logic [31:0] ad);
        i_core.take(n);
        #1;
        chk("hit", {31'h0, h}, {31'h0, fast_vector_hit});
        chk("channel", {31'h0, c}, {31'h0, fast_vector_channel});
        chk("address", ad, fast_vector_address);
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_errors++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rows[0] = '{12'h050, 32'hFFFF_3412, 32'h0000_3412};
        rows[1] = '{12'h060, 32'h8000_0F01, 32'h8000_0F01};
        rows[2] = '{12'h064, 32'h4000_0203, 32'h4000_0203};
        rows[3] = '{12'h048, 32'hFA05_00FF, 32'h0000_0000};
        rows[4] = '{12'h04C, 32'hFFFF_FFFF, 32'h0000_0000};
        rows[5] = '{12'h084, 32'hFFFF_FFFF, 32'h0000_000F};
        rows[6] = '{12'h0F0, 32'hFFFF_FFFF, 32'h0000_0000};
        rows[7] = '{12'h090, 32'h7FFF_FFFF, 32'h0000_0000};
        keys = '{16'hFA05, 16'hBCAF, 16'hBEEF, 16'hBEEF};
        bit7 = 4'b1011;
        fires = 4'b1000;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        foreach (rows[i])
            rd(rows[i].a, 32'h0000_0000);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].w);
            chk("reset req", 32'h0, {31'h0, sys_reset_req});
            rd(rows[i].a, rows[i].e);
        end
        // keys one and two, key three with and without the request bit
        foreach (keys[i])
        begin
            wr(12'h048, {keys[i], 8'h00, bit7[i], 7'h00});
            chk("reset req", {31'h0, fires[i]}, {31'h0, sys_reset_req});
            @(posedge core_clk);
            #1;
            chk("reset req end", 32'h0, {31'h0, sys_reset_req});
        end
        wr(12'h090, 32'h8000_0000);
        chk("ctrl reset", 32'h1, {31'h0, sys_reset_req});
        // ------------------------------------------------------------
        // nesting, fast vectors and events
        // ------------------------------------------------------------
        i_core.pend(1'b1);
        rd(12'h04C, 32'h0000_0200);
        take_chk(8'h12, 1'b1, 1'b0, 32'h8000_0F00);
        @(posedge core_clk);
        #1;
        chk("event irq", 32'h1, {31'h0, event_irq});
        rd(12'h04C, 32'h0000_0301);
        take_chk(8'h34, 1'b1, 1'b1, 32'h4000_0202);
        rd(12'h04C, 32'h0000_0303);
        i_core.take(8'h55);
        rd(12'h04C, 32'h0000_0303);
        i_core.leave();
        rd(12'h04C, 32'h0000_0301);
        i_core.leave();
        rd(12'h04C, 32'h0000_0200);
        i_core.pend(1'b0);
        i_core.leave();
        rd(12'h04C, 32'h0000_0000);
        rd(12'h080, 32'h0000_000F);
        wr(12'h080, 32'h0000_0005);
        rd(12'h080, 32'h0000_000A);
        wr(12'h084, 32'h0000_0000);
        @(posedge core_clk);
        #1;
        chk("event masked", 32'h0, {31'h0, event_irq});
        wr(12'h080, 32'hFFFF_FFFF);
        rd(12'h080, 32'h0000_0000);
        // disabled channel gives no hit; channel 0 wins a shared number
        wr(12'h060, 32'h8000_0F00);
        take_chk(8'h12, 1'b0, 1'b0, 32'h0000_0000);
        i_core.leave();
        wr(12'h060, 32'h8000_0F01);
        wr(12'h050, 32'h0000_3434);
        take_chk(8'h34, 1'b1, 1'b0, 32'h8000_0F00);
        i_core.leave();
        // second reset in mid-run clears everything
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rd(12'h050, 32'h0000_0000);
        rd(12'h060, 32'h0000_0000);
        rd(12'h064, 32'h0000_0000);
        rd(12'h080, 32'h0000_0000);
        close_out();
    end
endmodule
